// file: rtl/ipm_ctrl.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module ipm_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              ext0_pin_n_in,
  input  wire logic              ext1_pin_n_in,
  input  wire logic              wdog_req_in,
  input  wire logic              timer0_overflow_flag_in,
  input  wire logic              timer1_overflow_flag_in,
  input  wire logic              serial_tx_done_in,
  input  wire logic              serial_rx_done_in,
  input  wire logic              timer2_overflow_flag_in,
  input  wire logic              timer2_ext_flag_in,
  input  wire logic              irq_ack_in,
  input  wire logic              irq_return_in,
  input  wire logic              core_ale_in,
  input  wire logic              core_prog_store_strobe_n_n_in,
  output logic                   irq_req_out,
  output logic [15:0]            irq_vector_out,
  output logic                   core_halt_out,
  output logic                   clk_stop_out,
  output logic                   addr_latch_strobe_out,
  output logic                   prog_store_strobe_n_out,
  output logic                   irq_out
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ipm_ctrl: ADDR_W must be 8 to 32");
  end

  localparam int N = ipm_pkg::IPM_NSRC;

  // ==========================================================
  // Register decode, shared by read and write
  function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    if (ADDR_W > 8 && (a >> 8) != '0) return 4'hf;
    unique case ({lo[7:2], 2'h0})
      ipm_pkg::IPM_OFF_ENABLE:   return 4'h0;
      ipm_pkg::IPM_OFF_PRIO_LO:  return 4'h1;
      ipm_pkg::IPM_OFF_PRIO_HI:  return 4'h2;
      ipm_pkg::IPM_OFF_POWER:    return 4'h3;
      ipm_pkg::IPM_OFF_EXT_MODE: return 4'h4;
      ipm_pkg::IPM_OFF_FLAGS:    return 4'h5;
      ipm_pkg::IPM_OFF_DISPATCH: return 4'h6;
      ipm_pkg::IPM_OFF_EVT_STAT: return 4'h7;
      ipm_pkg::IPM_OFF_EVT_MASK: return 4'h8;
      default:                   return 4'hf;
    endcase
  endfunction

  // Highest in-service level
  function automatic logic [1:0] top_lvl(input logic [3:0] s);
    for (int i = 3; i >= 0; i--) begin
      if (s[i]) return 2'(i);
    end
    return 2'h0;
  endfunction

  ipm_pkg::ipm_pwr_e pwr_q;
  logic [N-1:0]      en_q, plo_q, phi_q, raw, pend;
  logic [1:0]        mode_q, ext_s1_q, ext_s2_q, ext_d_q, edge_q;
  logic [1:0]        wake_src_q, wake_latch_q, ext_low, ext_fall, ext_flag, wake_cand;
  logic [3:0]        isr_q, isr_d;
  logic [2:0]        evt_q, evt_set, mask_q, idx_q;
  logic [1:0]        lvl_q;
  logic              req_q, take, wake_go, grant;
  logic [2:0]        grant_idx;
  logic [1:0]        grant_lvl;
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [31:0]       wdata_q, rdata_q;
  logic [3:0]        wstrb_q, wsel, rsel;
  logic [1:0]        bresp_q, rresp_q;
  logic              wr_exec, rd_exec, halt_q, stop_q, ale_q, prog_store_strobe_n_n_q, irq_q;

  // ==========================================================
  // External pins: two-flop sync, then edge and level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_s1_q <= 2'h3;
      ext_s2_q <= 2'h3;
      ext_d_q  <= 2'h3;
    end else begin
      ext_s1_q <= {ext1_pin_n_in, ext0_pin_n_in};
      ext_s2_q <= ext_s1_q;
      ext_d_q  <= ext_s2_q;
    end
  end

  assign ext_low   = ~ext_s2_q;
  assign ext_fall  = ext_d_q & ~ext_s2_q;
  assign take      = irq_ack_in & req_q;

  for (genvar j = 0; j < 2; j++) begin : g_ext
    localparam logic [2:0] SRC = j ? ipm_pkg::IPM_SRC_EXT1 : ipm_pkg::IPM_SRC_EXT0;
    // Edge flag: a new edge in the taking cycle is kept
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        edge_q[j] <= 1'b0;
      end else if (mode_q[j] && ext_fall[j]) begin
        edge_q[j] <= 1'b1;
      end else if (take && idx_q == SRC) begin
        edge_q[j] <= 1'b0;
      end
    end
    assign ext_flag[j]  = mode_q[j] ? edge_q[j] : (ext_low[j] | wake_latch_q[j]);
    assign wake_cand[j] = ext_low[j] && en_q[SRC] && !mode_q[j];
  end

  // ==========================================================
  // Request gathering and arbitration
  assign raw = {timer2_overflow_flag_in | timer2_ext_flag_in,
                serial_tx_done_in | serial_rx_done_in,
                timer1_overflow_flag_in, ext_flag[1], timer0_overflow_flag_in,
                wdog_req_in, ext_flag[0]};
  // Clock is stopped in power-down, so nothing is offered there
  assign pend = (pwr_q == ipm_pkg::IPM_PWR_SLEEP || pwr_q == ipm_pkg::IPM_PWR_WAKE) ?
                '0 : raw & en_q;

  ipm_arbiter #(.NSRC(N)) u_arb (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .req_in        (pend),
    .prio_lo_in    (plo_q),
    .prio_hi_in    (phi_q),
    .active_in     (|isr_q),
    .cur_lvl_in    (top_lvl(isr_q)),
    .grant_out     (grant),
    .grant_idx_out (grant_idx),
    .grant_lvl_out (grant_lvl)
  );

  // Offer drops for one cycle after a take so the new level can settle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_q          <= 1'b0;
      idx_q          <= 3'h0;
      lvl_q          <= 2'h0;
      irq_vector_out <= 16'h0000;
    end else begin
      req_q          <= grant && !take;
      idx_q          <= grant_idx;
      lvl_q          <= grant_lvl;
      irq_vector_out <= ipm_pkg::IPM_VECTORS[grant_idx];
    end
  end

  always_comb begin
    isr_d = isr_q;
    if (irq_return_in) isr_d[top_lvl(isr_q)] = 1'b0;
    if (take) isr_d[lvl_q] = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) isr_q <= 4'h0;
    else isr_q <= isr_d;
  end

  // ==========================================================
  // Power state
  assign wake_go = pwr_q == ipm_pkg::IPM_PWR_WAKE && !(|(wake_src_q & ext_low));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pwr_q      <= ipm_pkg::IPM_PWR_RUN;
      wake_src_q <= 2'h0;
    end else begin
      unique case (pwr_q)
        ipm_pkg::IPM_PWR_RUN: begin
          if (wr_exec && wsel == 4'h3 && wstrb_q[0]) begin
            if (wdata_q[ipm_pkg::IPM_PWR_SLEEP_BIT]) pwr_q <= ipm_pkg::IPM_PWR_SLEEP;
            else if (wdata_q[ipm_pkg::IPM_PWR_DOZE_BIT]) pwr_q <= ipm_pkg::IPM_PWR_DOZE;
          end
        end
        ipm_pkg::IPM_PWR_DOZE: begin
          if (take) pwr_q <= ipm_pkg::IPM_PWR_RUN;
        end
        ipm_pkg::IPM_PWR_SLEEP: begin
          if (|wake_cand) begin
            pwr_q      <= ipm_pkg::IPM_PWR_WAKE;
            wake_src_q <= wake_cand;
          end
        end
        ipm_pkg::IPM_PWR_WAKE: begin
          if (wake_go) pwr_q <= ipm_pkg::IPM_PWR_RESUME;
        end
        ipm_pkg::IPM_PWR_RESUME: begin
          if (take) pwr_q <= ipm_pkg::IPM_PWR_RUN;
        end
        default: pwr_q <= ipm_pkg::IPM_PWR_RUN;
      endcase
    end
  end

  // Pin is high again by now, so the level request is held here
  always_ff @(posedge clk_in) begin
    if (rst_in) wake_latch_q <= 2'h0;
    else if (wake_go) wake_latch_q <= wake_src_q;
    else if (take && idx_q == ipm_pkg::IPM_SRC_EXT0) wake_latch_q[0] <= 1'b0;
    else if (take && idx_q == ipm_pkg::IPM_SRC_EXT1) wake_latch_q[1] <= 1'b0;
  end

  // Outputs lag the state by one clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      halt_q   <= 1'b0;
      stop_q   <= 1'b0;
      ale_q    <= 1'b1;
      prog_store_strobe_n_n_q <= 1'b1;
    end else begin
      halt_q <= pwr_q != ipm_pkg::IPM_PWR_RUN;
      stop_q <= pwr_q == ipm_pkg::IPM_PWR_SLEEP;
      unique case (pwr_q)
        ipm_pkg::IPM_PWR_RUN: begin
          ale_q    <= core_ale_in;
          prog_store_strobe_n_n_q <= core_prog_store_strobe_n_n_in;
        end
        ipm_pkg::IPM_PWR_SLEEP, ipm_pkg::IPM_PWR_WAKE: begin
          ale_q    <= 1'b0;
          prog_store_strobe_n_n_q <= 1'b0;
        end
        default: begin
          ale_q    <= 1'b1;
          prog_store_strobe_n_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Event status, cleared by reading it; a new event wins
  assign evt_set = {wake_go, take && pwr_q == ipm_pkg::IPM_PWR_DOZE, take};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      evt_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      evt_q <= ((rd_exec && rsel == 4'h7) ? 3'h0 : evt_q) | evt_set;
      irq_q <= |(evt_q & mask_q);
    end
  end

  // ==========================================================
  // AXI4-Lite write
  assign wsel    = reg_sel(awaddr_q);
  assign wr_exec = !awready_q && !wready_q && !bvalid_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= ipm_pkg::IPM_RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (awready_q && s_axi_awvalid_in) begin
        awready_q <= 1'b0;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (wready_q && s_axi_wvalid_in) begin
        wready_q <= 1'b0;
        wdata_q  <= s_axi_wdata_in;
        wstrb_q  <= s_axi_wstrb_in;
      end
      if (wr_exec) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (wsel == 4'hf) ? ipm_pkg::IPM_RESP_SLVERR : ipm_pkg::IPM_RESP_OKAY;
      end
      if (bvalid_q && s_axi_bready_in) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      en_q   <= ipm_pkg::IPM_RST_ENABLE;
      plo_q  <= ipm_pkg::IPM_RST_PRIO;
      phi_q  <= ipm_pkg::IPM_RST_PRIO;
      mode_q <= ipm_pkg::IPM_RST_EXT_MODE;
      mask_q <= ipm_pkg::IPM_RST_EVT_MASK;
    end else if (wr_exec && wstrb_q[0]) begin
      unique case (wsel)
        4'h0:    en_q   <= wdata_q[N-1:0];
        4'h1:    plo_q  <= wdata_q[N-1:0];
        4'h2:    phi_q  <= wdata_q[N-1:0];
        4'h4:    mode_q <= wdata_q[1:0];
        4'h8:    mask_q <= wdata_q[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read
  assign rsel    = reg_sel(araddr_q);
  assign rd_exec = !arready_q && !rvalid_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      araddr_q  <= '0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= ipm_pkg::IPM_RESP_OKAY;
    end else begin
      if (arready_q && s_axi_arvalid_in) begin
        arready_q <= 1'b0;
        araddr_q  <= s_axi_araddr_in;
      end
      if (rd_exec) begin
        rvalid_q <= 1'b1;
        rresp_q  <= (rsel == 4'hf) ? ipm_pkg::IPM_RESP_SLVERR : ipm_pkg::IPM_RESP_OKAY;
        unique case (rsel)
          4'h0:    rdata_q <= 32'(en_q);
          4'h1:    rdata_q <= 32'(plo_q);
          4'h2:    rdata_q <= 32'(phi_q);
          4'h3:    rdata_q <= 32'({pwr_q[1], pwr_q == ipm_pkg::IPM_PWR_DOZE});
          4'h4:    rdata_q <= 32'(mode_q);
          4'h5:    rdata_q <= 32'(raw);
          4'h6:    rdata_q <= 32'({pwr_q, isr_q, req_q, idx_q});
          4'h7:    rdata_q <= 32'(evt_q);
          4'h8:    rdata_q <= 32'(mask_q);
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
      if (rvalid_q && s_axi_rready_in) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready_out       = awready_q;
  assign s_axi_wready_out        = wready_q;
  assign s_axi_bvalid_out        = bvalid_q;
  assign s_axi_bresp_out         = bresp_q;
  assign s_axi_arready_out       = arready_q;
  assign s_axi_rvalid_out        = rvalid_q;
  assign s_axi_rdata_out         = rdata_q;
  assign s_axi_rresp_out         = rresp_q;
  assign irq_req_out             = req_q;
  assign core_halt_out           = halt_q;
  assign clk_stop_out            = stop_q;
  assign addr_latch_strobe_out   = ale_q;
  assign prog_store_strobe_n_out = prog_store_strobe_n_n_q;
  assign irq_out                 = irq_q;

  // ==========================================================
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_vector_match: assert property (req_q |-> irq_vector_out == ipm_pkg::IPM_VECTORS[idx_q])
    else $error("offered vector does not match source");
  a_serial_req: assert property (
    (serial_tx_done_in || serial_rx_done_in) && en_q[ipm_pkg::IPM_SRC_SER]
    && pwr_q == ipm_pkg::IPM_PWR_RUN |-> pend[ipm_pkg::IPM_SRC_SER])
    else $error("serial flag did not raise a request");
  a_doze_halt: assert property (pwr_q == ipm_pkg::IPM_PWR_DOZE |=> core_halt_out && !clk_stop_out)
    else $error("idle does not halt core only");
  a_doze_strobes: assert property (
    pwr_q == ipm_pkg::IPM_PWR_DOZE |=> addr_latch_strobe_out && prog_store_strobe_n_out)
    else $error("strobes not high in idle");
  a_doze_exit: assert property (pwr_q == ipm_pkg::IPM_PWR_DOZE && take |=> pwr_q == ipm_pkg::IPM_PWR_RUN ##1 !core_halt_out)
    else $error("idle not left on service start");
  // Must not be gated by reset itself, or it could never fire
  a_reset_run: assert property (
    @(posedge clk_in) disable iff (1'b0)
    rst_in |=> pwr_q == ipm_pkg::IPM_PWR_RUN && isr_q == 4'h0)
    else $error("reset did not end low-power state");
  a_sleep_stop: assert property (pwr_q == ipm_pkg::IPM_PWR_SLEEP [*2] |-> clk_stop_out && !req_q)
    else $error("power-down clock or request wrong");
  a_sleep_strobes: assert property (
    pwr_q == ipm_pkg::IPM_PWR_SLEEP |=> !addr_latch_strobe_out && !prog_store_strobe_n_out)
    else $error("strobes not low in power-down");
  a_wake_order: assert property (wake_go |=> pwr_q == ipm_pkg::IPM_PWR_RESUME && wake_latch_q != 2'h0)
    else $error("wake did not latch its source");
  a_resume_exit: assert property (
    pwr_q == ipm_pkg::IPM_PWR_RESUME && take |=> pwr_q == ipm_pkg::IPM_PWR_RUN ##1 !core_halt_out)
    else $error("power-down bit not cleared on service");
  a_preempt_level: assert property (take && |isr_q |-> lvl_q > top_lvl(isr_q))
    else $error("take without higher level");

  c_idle_exit:  cover property (pwr_q == ipm_pkg::IPM_PWR_DOZE ##1 pwr_q == ipm_pkg::IPM_PWR_RUN);
  c_wake_path:  cover property (pwr_q == ipm_pkg::IPM_PWR_WAKE ##[1:200] pwr_q == ipm_pkg::IPM_PWR_RUN);
  c_preempt:    cover property (take && isr_q != 4'h0);
  c_status_irq: cover property (irq_out);

endmodule // ipm_ctrl

// file: rtl/ipm_pkg.sv
package ipm_pkg;

  // ==========================================================
  // Sources, in polling order
  localparam int          IPM_NSRC      = 7;
  localparam logic [2:0]  IPM_SRC_EXT0  = 3'h0;
  localparam logic [2:0]  IPM_SRC_WDOG  = 3'h1;
  localparam logic [2:0]  IPM_SRC_TMR0  = 3'h2;
  localparam logic [2:0]  IPM_SRC_EXT1  = 3'h3;
  localparam logic [2:0]  IPM_SRC_TMR1  = 3'h4;
  localparam logic [2:0]  IPM_SRC_SER   = 3'h5;
  localparam logic [2:0]  IPM_SRC_TMR2  = 3'h6;

  // Index 0 is the last element
  localparam logic [6:0][15:0] IPM_VECTORS = {
    16'h002b, 16'h0023, 16'h001b, 16'h0013,
    16'h000b, 16'h0053, 16'h0003};

  // ==========================================================
  // Register offsets
  localparam logic [7:0]  IPM_OFF_ENABLE   = 8'h00;
  localparam logic [7:0]  IPM_OFF_PRIO_LO  = 8'h04;
  localparam logic [7:0]  IPM_OFF_PRIO_HI  = 8'h08;
  localparam logic [7:0]  IPM_OFF_POWER    = 8'h0c;
  localparam logic [7:0]  IPM_OFF_EXT_MODE = 8'h10;
  localparam logic [7:0]  IPM_OFF_FLAGS    = 8'h14;
  localparam logic [7:0]  IPM_OFF_DISPATCH = 8'h18;
  localparam logic [7:0]  IPM_OFF_EVT_STAT = 8'h1c;
  localparam logic [7:0]  IPM_OFF_EVT_MASK = 8'h20;

  // ==========================================================
  // Fields and reset values
  localparam int          IPM_PWR_DOZE_BIT  = 0;
  localparam int          IPM_PWR_SLEEP_BIT = 1;
  localparam int          IPM_EVT_TAKE      = 0;
  localparam int          IPM_EVT_IDLE_EXIT = 1;
  localparam int          IPM_EVT_WAKE      = 2;
  localparam logic [6:0]  IPM_RST_ENABLE    = 7'h00;
  localparam logic [6:0]  IPM_RST_PRIO      = 7'h00;
  localparam logic [1:0]  IPM_RST_EXT_MODE  = 2'h0;
  localparam logic [2:0]  IPM_RST_EVT_MASK  = 3'h0;
  localparam logic [1:0]  IPM_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  IPM_RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    IPM_PWR_RUN    = 3'h0,
    IPM_PWR_DOZE   = 3'h1,
    IPM_PWR_SLEEP  = 3'h3,
    IPM_PWR_WAKE   = 3'h2,
    IPM_PWR_RESUME = 3'h6
  } ipm_pwr_e;

endpackage

// file: rtl/ipm_arbiter.sv
`timescale 1ns/1ps
module ipm_arbiter #(
  parameter int NSRC = 7
) (
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [NSRC-1:0] req_in,
  input  wire logic [NSRC-1:0] prio_lo_in,
  input  wire logic [NSRC-1:0] prio_hi_in,
  input  wire logic            active_in,
  input  wire logic [1:0]      cur_lvl_in,
  output logic                 grant_out,
  output logic [2:0]           grant_idx_out,
  output logic [1:0]           grant_lvl_out
);

  if (NSRC < 1 || NSRC > 8) begin : g_bad_nsrc
    $error("ipm_arbiter: NSRC must be 1 to 8");
  end

  logic            found;
  logic [1:0]      best_lvl;
  logic [2:0]      best_idx;
  logic [NSRC-1:0] same_lvl;

  // ==========================================================
  // Highest level wins, lower poll index breaks ties
  always_comb begin
    found    = 1'b0;
    best_lvl = 2'h0;
    best_idx = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req_in[i] && (!found || {prio_hi_in[i], prio_lo_in[i]} >= best_lvl)) begin
        found    = 1'b1;
        best_lvl = {prio_hi_in[i], prio_lo_in[i]};
        best_idx = 3'(i);
      end
    end
    // Only a strictly higher level preempts
    grant_out     = found && (!active_in || best_lvl > cur_lvl_in);
    grant_idx_out = best_idx;
    grant_lvl_out = best_lvl;
  end

  for (genvar g = 0; g < NSRC; g++) begin : g_same
    assign same_lvl[g] = req_in[g] && {prio_hi_in[g], prio_lo_in[g]} == best_lvl;
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_level_bits: assert property (
    grant_out |-> grant_lvl_out == {prio_hi_in[grant_idx_out], prio_lo_in[grant_idx_out]})
    else $error("grant level does not match priority bits");
  a_poll_order: assert property (
    grant_out |-> (same_lvl & NSRC'((8'h01 << grant_idx_out) - 8'h01)) == '0)
    else $error("earlier source at same level was skipped");

endmodule // ipm_arbiter

// file: testbench/ipm_core_model.sv
`timescale 1ns/1ps
module ipm_core_model (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic req_in,
  input  wire logic hold_in,
  output logic      ack_out,
  output logic      ret_out
);
  // ==========================================================
  // Core side: one service at a time, hold_in stalls it
  int cnt_q;
  always_ff @(posedge clk_in) begin
    ack_out <= !rst_in && cnt_q == 0 && req_in && !hold_in;
    ret_out <= !rst_in && cnt_q == 1;
    if (rst_in) begin
      cnt_q <= 0;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end else if (req_in && !hold_in) begin
      cnt_q <= 5; // Pause before return, like padding no-ops
    end
  end
endmodule // ipm_core_model

// file: testbench/ipm_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ipm_ctrl_tb_top;
  // ==========================================================
  // Stimulus and wiring
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, rdy = 1'b1, hold = 1'b1;
  logic [6:0]  src = 7'h0, s, en, lo, hi;
  logic [2:0]  rnd = 3'h0;
  logic [33:0] d;
  logic        awr, wr_r, bv, arr, rv, req, halt, stp, ale, psn, irq, ack, ret;
  logic [1:0]  rresp, bresp;
  logic [31:0] rdata;
  logic [15:0] vec;
  int          errors = 0, n_compared = 0, k, n;
  localparam logic [15:0] VT [7] = '{16'h0003, 16'h0053, 16'h000b, 16'h0013,
                                     16'h001b, 16'h0023, 16'h002b};
  ipm_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .s_axi_awaddr_in(addr),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(rdy),
    .s_axi_araddr_in(addr), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rdy), .ext0_pin_n_in(~src[0]), .ext1_pin_n_in(~src[3]),
    .wdog_req_in(src[1]), .timer0_overflow_flag_in(src[2]),
    .timer1_overflow_flag_in(src[4]), .serial_tx_done_in(src[5] & rnd[2]),
    .serial_rx_done_in(src[5] & ~rnd[2]), .timer2_overflow_flag_in(src[6] & rnd[2]),
    .timer2_ext_flag_in(src[6] & ~rnd[2]), .irq_ack_in(ack), .irq_return_in(ret),
    .core_ale_in(rnd[0]), .core_prog_store_strobe_n_n_in(rnd[1]), .irq_req_out(req),
    .irq_vector_out(vec), .core_halt_out(halt), .clk_stop_out(stp),
    .addr_latch_strobe_out(ale), .prog_store_strobe_n_out(psn), .irq_out(irq));
  ipm_core_model core (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
    .hold_in(hold), .ack_out(ack), .ret_out(ret));
  initial forever #10 clk_in = ~clk_in;
  always @(posedge clk_in) rnd <= 3'($urandom);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] exp_vec(input logic [6:0] r, l, h);
    int b;
    b = -1;
    for (int i = 6; i >= 0; i--)
      if (r[i] && (b < 0 || {h[i], l[i]} >= {h[b], l[b]})) b = i;
    return VT[b];
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic b;
    b = 1'b0;
    addr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!b) begin
      @(posedge clk_in);
      b = bv;
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [33:0] v);
    logic b;
    b = 1'b0;
    addr <= a;
    arv <= 1'b1;
    while (!b) begin
      @(posedge clk_in);
      b = rv;
      v = {rresp, rdata};
      if (arr) arv <= 1'b0;
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200us;
    errors++;
    finish_test();
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(32'h73f4));
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(8'h40, d);
    `CHK(d, {2'h2, 32'h0});
    wr(8'h44, 32'h7f);
    `CHK(bresp, 2'h2);
    for (k = 0; k < 24; k++) begin
      s = (k < 7) ? 7'h1 << k : 7'($urandom);
      en = (k < 7) ? 7'h7f : 7'($urandom) | 7'h10;
      lo = (k < 7) ? 7'h0 : 7'($urandom);
      hi = (k < 7) ? 7'h0 : 7'($urandom);
      hold <= 1'b1;
      wr(8'h00, {25'h0, en});
      wr(8'h04, {25'h0, lo});
      wr(8'h08, {25'h0, hi});
      src <= s;
      repeat (6) @(posedge clk_in);
      `CHK(req, |(s & en));
      if (|(s & en)) `CHK(vec, exp_vec(s & en, lo, hi));
      hold <= 1'b0;
      repeat (30) @(posedge clk_in);
      src <= 7'h0;
      repeat (20) @(posedge clk_in);
    end
    `CHK(irq, 1'b0);
    wr(8'h20, 32'h7);
    `CHK(bresp, 2'h0);
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b1);
    rd(8'h1c, d);
    `CHK(d, 34'h1);
    wr(8'h00, 32'h7f);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    // Edge mode on ext0: a short low pulse must be remembered until served
    hold <= 1'b1;
    wr(8'h10, 32'h1);
    src <= 7'h01;
    repeat (3) @(posedge clk_in);
    src <= 7'h0;
    repeat (8) @(posedge clk_in);
    `CHK({req, vec}, 17'h1_0003);
    hold <= 1'b0;
    repeat (12) @(posedge clk_in);
    `CHK(req, 1'b0);
    hold <= 1'b1;
    wr(8'h0c, 32'h1);
    repeat (3) @(posedge clk_in);
    `CHK({halt, ale, psn}, 3'h7);
    src <= 7'h04;
    hold <= 1'b0;
    for (n = 0; n < 40 && halt !== 1'b0; n++) @(posedge clk_in);
    `CHK(halt, 1'b0);
    src <= 7'h0;
    rd(8'h0c, d);
    `CHK(d, 34'h0);
    rd(8'h1c, d);
    `CHK(d, 34'h3);
    repeat (3) @(posedge clk_in);
    `CHK(irq, 1'b0);
    wr(8'h0c, 32'h2);
    src <= 7'h04;
    repeat (20) @(posedge clk_in);
    `CHK({stp, ale, psn, req}, 4'h8);
    src <= 7'h08;
    repeat (1024) @(posedge clk_in); // Pin held low
    `CHK({halt, req}, 2'h2);
    src <= 7'h0;
    for (n = 0; n < 40 && req !== 1'b1; n++) @(posedge clk_in);
    `CHK({req, vec}, 17'h1_0013);
    repeat (10) @(posedge clk_in);
    `CHK({stp, halt}, 2'h0);
    wr(8'h0c, 32'h2);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    `CHK({stp, halt, ale}, 3'h1);
    rd(8'h00, d);
    `CHK(d, 34'h0);
    finish_test();
  end
endmodule // ipm_ctrl_tb_top
